// file: pkg/fess_pkg.sv
package fess_pkg;
  // ***********************************
  // Timing
  // ***********************************
  localparam int CLK_NS        = 40;
  localparam int T_WP_NS       = 45;    // Write strobe low time
  localparam int T_ACC_NS      = 120;   // Read access time
  localparam int T_SUSP_MAX_NS = 10000; // Longest suspend entry
  localparam int T_WIN_NS      = 50000; // Sector collection window
  localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUSP_CYC = T_SUSP_MAX_NS / CLK_NS;
  localparam int WIN_CYC  = T_WIN_NS / CLK_NS;
  // ***********************************
  // Software registers
  // ***********************************
  localparam logic [1:0] REG_CMD  = 2'h0;
  localparam logic [1:0] REG_ADDR = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_STAT = 2'h3;
  // ***********************************
  // Flash command set
  // ***********************************
  localparam logic [18:0] UNL1_ADDR = 19'h0_5555;
  localparam logic [18:0] UNL2_ADDR = 19'h0_2AAA;
  localparam logic [7:0]  D_UNL1    = 8'hAA;
  localparam logic [7:0]  D_UNL2    = 8'h55;
  localparam logic [7:0]  D_SETUP   = 8'h80;
  localparam logic [7:0]  D_PROG    = 8'hA0;
  localparam logic [7:0]  D_CHIP    = 8'h10;
  localparam logic [7:0]  D_SECT    = 8'h30;
  localparam logic [7:0]  D_SUSP    = 8'hB0;
  localparam logic [7:0]  D_RESET   = 8'hF0;
  localparam int SEC_LSB = 16;
  // Status bit positions on the data bus
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TLIM_BIT   = 5;
  localparam int FSTAGE_BIT = 4;
  typedef enum logic [3:0] {
    OP_RESET  = 4'h0,
    OP_CHIP   = 4'h1,
    OP_SECT   = 4'h2,
    OP_ADD    = 4'h3,
    OP_SUSP   = 4'h4,
    OP_RESUME = 4'h5,
    OP_READ   = 4'h6,
    OP_PROG   = 4'h7,
    OP_POLL   = 4'h8
  } fess_op_t;
  typedef struct packed {
    logic [18:0] addr;
    logic [7:0]  dq;
    logic        dq_oe;
    logic        cs_n;
    logic        oe_n;
    logic        we_n;
  } fess_pins_t;
  typedef struct packed {
    logic       refused;
    logic       win_open;
    logic       susp_tout;
    logic       fail_erase;
    logic       fail;
    logic       busy;
    logic [7:0] mask;
    logic [7:0] last;
  } fess_stat_t;
endpackage : fess_pkg

// file: verilog/fess_host.sv
// What this block does
// - Chip erase is six writes: two unlocks, set-up, two unlocks, erase.
// - Unlocks go to 5555H and 2AAAH; set-up 80H, chip erase 10H.
// - Further 30H writes in the window add sectors and restart timer.
// - Sectors 0 to 7 may be selected in any order and number.
// - Host polls sector erase inside an erasing sector until bit 1.
// - Suspend takes up to 10us; wait for toggle stop elsewhere.
// - Time limit flag 1 means failure; host writes reset to recover.
// - Byte programming at any address order, across sectors.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fess_host #(
  parameter int unsigned WIN_CYC = fess_pkg::WIN_CYC
) (
  // Clock and reset
  input  wire logic          MCLK_I,
  input  wire logic          RST_I,
  // Software port
  input  wire logic [1:0]    ADDR_I,
  input  wire logic [31:0]   WDATA_I,
  input  wire logic          WR_I,
  input  wire logic          RD_I,
  output logic [31:0]        RDATA_O,
  output logic               BUSY_O,
  // Flash pins
  output fess_pkg::fess_pins_t FL_O,
  input  wire logic [7:0]    FL_DQ_I
);
  // ***********************************
  // State and storage
  // ***********************************
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_WSET = 6'h02,
    S_WLO  = 6'h04,
    S_WHI  = 6'h08,
    S_RLO  = 6'h10,
    S_RCHK = 6'h20
  } fess_state_t;
  fess_state_t        state;
  fess_pkg::fess_op_t op;
  fess_pkg::fess_stat_t st;
  logic        refused;
  logic        fail;
  logic        fail_erase;
  logic        susp_tout;
  logic [7:0]  sect_mask;
  logic [7:0]  last_read;
  logic [18:0] addr_reg;
  logic [7:0]  data_reg;
  logic [18:0] rd_addr;
  logic [2:0]  idx;
  logic [3:0]  cnt;
  logic        prev_tog;
  logic        have_prev;
  logic [15:0] win_cnt;
  logic [8:0]  susp_cnt;
  logic        start;
  logic        cmd_wr;
  logic [26:0] word;
  logic        last_wr;
  logic [2:0]  sect;
  fess_pkg::fess_op_t wop;

  assign wop    = fess_pkg::fess_op_t'(WDATA_I[3:0]);
  assign cmd_wr = WR_I && ADDR_I == fess_pkg::REG_CMD;
  assign start  = cmd_wr && state == S_IDLE &&
                  !(wop == fess_pkg::OP_ADD && !st.win_open);
  assign sect   = addr_reg[fess_pkg::SEC_LSB +: 3];

  function automatic logic [2:0] nwr(input fess_pkg::fess_op_t o);
    case (o)
      fess_pkg::OP_CHIP, fess_pkg::OP_SECT: nwr = 3'h6;
      fess_pkg::OP_PROG:                    nwr = 3'h4;
      fess_pkg::OP_READ, fess_pkg::OP_POLL: nwr = 3'h0;
      default:                              nwr = 3'h1;
    endcase
  endfunction : nwr

  // First sector whose mask bit equals want
  function automatic logic [2:0] pick(input logic [7:0] m, input logic want);
    pick = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i] == want) begin
        pick = 3'(i);
      end
    end
  endfunction : pick

  // Address and data of write idx of the current operation
  always_comb begin
    word = {addr_reg, fess_pkg::D_SECT};
    case (op)
      fess_pkg::OP_RESET:  word = {fess_pkg::UNL1_ADDR, fess_pkg::D_RESET};
      fess_pkg::OP_SUSP:   word = {addr_reg, fess_pkg::D_SUSP};
      fess_pkg::OP_ADD,
      fess_pkg::OP_RESUME: word = {addr_reg, fess_pkg::D_SECT};
      default: begin
        case (idx)
          3'h0, 3'h3: word = {fess_pkg::UNL1_ADDR, fess_pkg::D_UNL1};
          3'h1, 3'h4: word = {fess_pkg::UNL2_ADDR, fess_pkg::D_UNL2};
          3'h2:       word = {fess_pkg::UNL1_ADDR, fess_pkg::D_SETUP};
          default:    word = {fess_pkg::UNL1_ADDR, fess_pkg::D_CHIP};
        endcase
        if (op == fess_pkg::OP_PROG && idx == 3'h2) begin
          word = {fess_pkg::UNL1_ADDR, fess_pkg::D_PROG};
        end
        if (op == fess_pkg::OP_PROG && idx == 3'h3) begin
          word = {addr_reg, data_reg}; // Any address order
        end
        if (op == fess_pkg::OP_SECT && idx == 3'h5) begin
          word = {addr_reg, fess_pkg::D_SECT};
        end
      end
    endcase
  end
  assign last_wr = idx == 3'(nwr(op) - 3'h1);

  // ***********************************
  // Software registers
  // ***********************************
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      addr_reg <= 19'h0_0000;
      data_reg <= 8'h00;
    end else if (WR_I && ADDR_I == fess_pkg::REG_ADDR) begin
      addr_reg <= WDATA_I[18:0];
    end else if (WR_I && ADDR_I == fess_pkg::REG_DATA) begin
      data_reg <= WDATA_I[7:0];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (RD_I) begin
      case (ADDR_I)
        fess_pkg::REG_ADDR: RDATA_O <= {13'h0000, addr_reg};
        fess_pkg::REG_DATA: RDATA_O <= {24'h00_0000, data_reg};
        fess_pkg::REG_STAT: RDATA_O <= {10'h000, st.refused, st.win_open,
                                        st.susp_tout, st.fail_erase,
                                        st.fail, st.busy, st.mask, st.last};
        default:            RDATA_O <= 32'h0000_0000;
      endcase
    end else begin
      RDATA_O <= 32'h0000_0000;
    end
  end

  // Refusal is sticky; a new refusal beats the clearing write
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      refused <= 1'b0;
    end else if (cmd_wr && !start) begin
      refused <= 1'b1;
    end else if (WR_I && ADDR_I == fess_pkg::REG_STAT) begin
      refused <= 1'b0;
    end
  end

  // ***********************************
  // Sector set and collection window
  // ***********************************
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      sect_mask <= 8'h00;
    end else if (start && wop == fess_pkg::OP_SECT) begin
      sect_mask <= 8'h01 << sect;
    end else if (start && wop == fess_pkg::OP_ADD) begin
      sect_mask <= sect_mask | (8'h01 << sect);
    end else if (start && wop == fess_pkg::OP_CHIP) begin
      sect_mask <= 8'hFF;
    end
  end

  // Host copy of the device timer; only a guide, the device decides
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      win_cnt <= 16'h0000;
    end else if (state == S_WHI && last_wr &&
                 (op == fess_pkg::OP_SECT || op == fess_pkg::OP_ADD)) begin
      win_cnt <= 16'(WIN_CYC);
    end else if (start && wop != fess_pkg::OP_ADD &&
                 wop != fess_pkg::OP_READ && wop != fess_pkg::OP_POLL) begin
      win_cnt <= 16'h0000; // Other command except read or poll aborts, suspend ends it
    end else if (win_cnt != 16'h0000) begin
      win_cnt <= win_cnt - 16'h0001;
    end
  end
  // One driver for the whole status word
  assign st = '{refused: refused, win_open: win_cnt != 16'h0000,
                susp_tout: susp_tout, fail_erase: fail_erase, fail: fail,
                busy: state != S_IDLE, mask: sect_mask, last: last_read};

  always_ff @(posedge MCLK_I) begin
    if (RST_I || state == S_IDLE) begin
      susp_cnt <= 9'h000;
    end else if (op == fess_pkg::OP_SUSP && susp_cnt != 9'(fess_pkg::SUSP_CYC)) begin
      susp_cnt <= susp_cnt + 9'h001;
    end
  end

  // ***********************************
  // Bus sequencer
  // ***********************************
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state         <= S_IDLE;
      op            <= fess_pkg::OP_RESET;
      idx           <= 3'h0;
      cnt           <= 4'h0;
      rd_addr       <= 19'h0_0000;
      prev_tog      <= 1'b0;
      have_prev     <= 1'b0;
      last_read     <= 8'h00;
      fail          <= 1'b0;
      fail_erase    <= 1'b0;
      susp_tout     <= 1'b0;
      FL_O          <= '{addr: 19'h0_0000, dq: 8'h00, dq_oe: 1'b0,
                         cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else begin
      case (state)
        S_IDLE: begin
          if (start) begin
            op            <= wop;
            idx           <= 3'h0;
            have_prev     <= 1'b0;
            fail          <= 1'b0;
            susp_tout     <= 1'b0;
            // Erase polls an erasing sector, suspend reads an idle one
            case (wop)
              fess_pkg::OP_POLL: rd_addr <= {pick(st.mask, 1'b1), 16'h0000};
              fess_pkg::OP_SUSP: rd_addr <= {pick(st.mask, 1'b0), 16'h0000};
              default:           rd_addr <= addr_reg;
            endcase
            state <= (nwr(wop) == 3'h0) ? S_RLO : S_WSET;
            cnt   <= 4'h0;
          end
        end
        S_WSET: begin
          {FL_O.addr, FL_O.dq} <= word;
          FL_O.dq_oe <= 1'b1;
          FL_O.cs_n  <= 1'b0;
          FL_O.we_n  <= 1'b0; // Falls on the same edge that drives address and data
          cnt        <= 4'h0;
          state      <= S_WLO;
        end
        S_WLO: begin
          cnt <= cnt + 4'h1;
          if (cnt == 4'(fess_pkg::WP_CYC - 1)) begin
            FL_O.we_n <= 1'b1; // Data held through the rise
            state     <= S_WHI;
          end
        end
        S_WHI: begin
          FL_O.cs_n  <= 1'b1;
          FL_O.dq_oe <= 1'b0;
          cnt        <= 4'h0;
          if (!last_wr) begin
            idx   <= idx + 3'h1;
            state <= S_WSET;
          end else if (op == fess_pkg::OP_CHIP || op == fess_pkg::OP_PROG ||
                       op == fess_pkg::OP_SUSP) begin
            state <= S_RLO;
          end else begin
            state <= S_IDLE;
          end
        end
        S_RLO: begin
          FL_O.addr <= rd_addr;
          FL_O.cs_n <= 1'b0;
          FL_O.oe_n <= 1'b0;
          cnt       <= cnt + 4'h1;
          if (cnt == 4'(fess_pkg::ACC_CYC - 1)) begin
            state <= S_RCHK;
          end
        end
        S_RCHK: begin
          FL_O.cs_n <= 1'b1;
          FL_O.oe_n <= 1'b1;
          last_read <= FL_DQ_I;
          prev_tog  <= FL_DQ_I[fess_pkg::TOGGLE_BIT];
          have_prev <= 1'b1;
          cnt       <= 4'h0;
          state     <= S_RLO;
          if (op == fess_pkg::OP_READ) begin
            state <= S_IDLE;
          end else if (op == fess_pkg::OP_SUSP) begin
            if (have_prev && prev_tog == FL_DQ_I[fess_pkg::TOGGLE_BIT]) begin
              state <= S_IDLE;
            end else if (susp_cnt == 9'(fess_pkg::SUSP_CYC)) begin
              susp_tout    <= 1'b1;
              state        <= S_IDLE;
            end
          end else if (op == fess_pkg::OP_PROG ?
                       FL_DQ_I[fess_pkg::POLL_BIT] == data_reg[fess_pkg::POLL_BIT] :
                       FL_DQ_I[fess_pkg::POLL_BIT]) begin
            state <= S_IDLE;
          end else if (FL_DQ_I[fess_pkg::TLIM_BIT]) begin
            fail          <= 1'b1;
            fail_erase    <= FL_DQ_I[fess_pkg::FSTAGE_BIT];
            op            <= fess_pkg::OP_RESET;
            idx           <= 3'h0;
            state         <= S_WSET;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      BUSY_O <= 1'b0;
    end else begin
      BUSY_O <= start || (state != S_IDLE && !(state == S_WHI && last_wr &&
                op != fess_pkg::OP_CHIP && op != fess_pkg::OP_PROG &&
                op != fess_pkg::OP_SUSP));
    end
  end

  // ***********************************
  // Checks
  // ***********************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  a_we_width: assert property ($fell(FL_O.we_n) |->
    (!FL_O.we_n)[*2] ##1 FL_O.we_n) else $error("write strobe width");
  a_addr_hold: assert property (!FL_O.we_n |=>
    $stable(FL_O.addr) && (FL_O.we_n || $stable(FL_O.dq)))
    else $error("address moved under strobe");
  a_data_rise: assert property ($rose(FL_O.we_n) |->
    FL_O.dq_oe && $stable(FL_O.dq)) else $error("data not held at rise");
  a_unlock_addr: assert property ($fell(FL_O.we_n) && idx == 3'h1 &&
    op != fess_pkg::OP_RESET |-> FL_O.addr == fess_pkg::UNL2_ADDR &&
    FL_O.dq == fess_pkg::D_UNL2) else $error("bad second unlock");
  a_chip_cmd: assert property ($fell(FL_O.we_n) &&
    op == fess_pkg::OP_CHIP && idx == 3'h5 |-> FL_O.dq == fess_pkg::D_CHIP
    ##4 state == S_RLO) else $error("chip erase sequence");
  a_fail_recover: assert property (state == S_RCHK &&
    op == fess_pkg::OP_CHIP && !FL_DQ_I[fess_pkg::POLL_BIT] &&
    FL_DQ_I[fess_pkg::TLIM_BIT] |=> st.fail &&
    st.fail_erase == $past(FL_DQ_I[fess_pkg::FSTAGE_BIT]) ##1
    FL_O.dq == fess_pkg::D_RESET) else $error("no recovery write");
  a_no_oe_we: assert property (!FL_O.oe_n |-> FL_O.we_n &&
    !FL_O.dq_oe) else $error("write while reading");
  a_susp_bound: assert property (op == fess_pkg::OP_SUSP &&
    state == S_RCHK && susp_cnt == 9'(fess_pkg::SUSP_CYC) |=>
    state == S_IDLE) else $error("suspend wait unbounded");
  a_win_close: assert property (start && wop == fess_pkg::OP_SUSP |=>
    !st.win_open) else $error("window left open");
  c_chip_done: cover property (op == fess_pkg::OP_CHIP && state == S_RCHK
    ##1 state == S_IDLE);
  c_sect_add: cover property (start && wop == fess_pkg::OP_ADD);
  c_susp_done: cover property (op == fess_pkg::OP_SUSP && $rose(state == S_IDLE));
  c_fail: cover property ($rose(st.fail));
endmodule : fess_host
`default_nettype wire

// file: sim/fess_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fess_flash_model #(
  parameter int WIN_CYC  = 20,
  parameter int BUSY_CYC = 60,
  parameter int SUSP_CYC = 8
) (
  // Timing reference and fault control
  input  wire logic                 clk_i,
  input  wire logic                 erase_fail_i,
  // Controller pins
  input  wire fess_pkg::fess_pins_t pins_i,
  output logic [7:0]                dq_o
);
  // ***********************************
  // Device state
  // ***********************************
  typedef enum logic [2:0] {
    s_rd, s_prog, s_win, s_erase, s_susp, s_fail
  } fess_mst_t;
  fess_mst_t   st      = s_rd;
  logic [7:0]  mem [int];
  logic [7:0]  sel     = 8'h00;
  logic [7:0]  pdata   = 8'h00;
  logic [7:0]  last    = 8'h00;
  logic [7:0]  val;
  logic [18:0] la      = 19'h0_0000;
  logic [18:0] paddr   = 19'h0_0000;
  logic        prev_we = 1'h1;
  logic        prev_oe = 1'h1;
  logic        tog     = 1'h0;
  logic        stage   = 1'h0;
  logic        lock    = 1'h0;
  int          seq     = 0;
  int          cnt     = 0;
  int          sp      = 0;
  function automatic logic [7:0] arr(input logic [18:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction : arr
  task automatic take(input logic [18:0] a, input logic [7:0] d);
    logic u1;
    logic u2;
    u1 = a[14:0] == fess_pkg::UNL1_ADDR[14:0];
    u2 = a[14:0] == fess_pkg::UNL2_ADDR[14:0];
    if (st == s_win && d == fess_pkg::D_SECT) begin
      sel[a[18:16]] = 1'h1;
      cnt = WIN_CYC;
    end else if (st == s_win && d == fess_pkg::D_SUSP) begin
      st = s_susp;
      cnt = 0;
    end else if (st == s_win) begin
      st = s_rd;
      sel = 8'h00;
    end else if (st == s_susp && d == fess_pkg::D_SECT) begin
      st = s_erase;
      cnt = BUSY_CYC;
    end else if (st == s_erase) begin
      if (d == fess_pkg::D_SUSP && sp == 0) sp = SUSP_CYC;
    end else if (st == s_fail) begin
      if (d == fess_pkg::D_RESET) st = s_rd;
    end else if (st == s_rd) begin
      if (d == fess_pkg::D_RESET) seq = 0;
      else if (seq == 0 || seq == 3) seq = (u1 && d == fess_pkg::D_UNL1) ? seq + 1 : 0;
      else if (seq == 1 || seq == 4) seq = (u2 && d == fess_pkg::D_UNL2) ? seq + 1 : 0;
      else if (seq == 2) seq = !u1 ? 0 : d == fess_pkg::D_SETUP ? 3 : d == fess_pkg::D_PROG ? 6 : 0;
      else if (seq == 5) begin
        seq = 0;
        if (u1 && d == fess_pkg::D_CHIP) begin
          sel = 8'hFF;
          st = s_erase;
          cnt = BUSY_CYC;
        end else if (d == fess_pkg::D_SECT) begin
          sel[a[18:16]] = 1'h1;
          st = s_win;
          cnt = WIN_CYC;
        end
      end else begin
        seq = 0;
        paddr = a;
        pdata = d;
        lock = arr(a) != 8'hFF;
        st = s_prog;
        cnt = BUSY_CYC / 4;
      end
    end
  endtask : take
  // ***********************************
  // Pin sampling, off the controller's edge to avoid races
  // ***********************************
  always @(negedge clk_i) begin
    if (prev_we && !pins_i.we_n && !pins_i.cs_n) la = pins_i.addr;
    if (!prev_we && pins_i.we_n && !pins_i.cs_n && pins_i.oe_n) take(la, pins_i.dq);
    if (prev_oe && !pins_i.oe_n && st != s_rd && st != s_susp) tog = ~tog;
    if (!pins_i.cs_n && !pins_i.oe_n) last = val;
    prev_we = pins_i.we_n;
    prev_oe = pins_i.oe_n;
    if (sp > 0) begin
      sp--;
      if (sp == 0) st = s_susp;
    end else if (cnt > 0) begin
      cnt--;
      if (cnt == 0 && st == s_prog && lock) begin
        st = s_fail;
        stage = 1'h0;
      end else if (cnt == 0 && st == s_prog) begin
        mem[int'(paddr)] = pdata;
        st = s_rd;
      end else if (cnt == 0 && st == s_win) begin
        st = s_erase;
        cnt = BUSY_CYC;
      end else if (cnt == 0 && st == s_erase && erase_fail_i) begin
        st = s_fail;
        stage = 1'h1;
      end else if (cnt == 0 && st == s_erase) begin
        foreach (mem[k]) if (sel[k[18:16]]) mem[k] = 8'hFF;
        sel = 8'h00;
        st = s_rd;
      end
    end
  end
  always_comb begin
    case (st)
      s_prog:  val = {~pdata[7], tog, 6'h00};
      s_win:   val = {1'h0, tog, 6'h00};
      s_erase: val = {1'h0, tog, 2'h0, 1'h1, 3'h0};
      // Erase failure keeps the poll bit low, program failure complements
      s_fail:  val = {~stage & ~pdata[7], tog, 1'h1, stage, 1'h1, 3'h0};
      s_susp:  val = sel[pins_i.addr[18:16]] ? 8'h08 : arr(pins_i.addr);
      default: val = arr(pins_i.addr);
    endcase
  end
  // Released bus shows the inverse of the last value, never a kind zero
  assign dq_o = (!pins_i.cs_n && !pins_i.oe_n) ? val : ~last;
endmodule : fess_flash_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int WIN   = 20;
  localparam int LIMIT = 20000;
  logic                 clk        = 1'h0;
  logic                 rst        = 1'h1;
  logic [1:0]           adr        = 2'h0;
  logic [31:0]          wd         = 32'h0000_0000;
  logic                 wr         = 1'h0;
  logic                 rd         = 1'h0;
  logic                 efail      = 1'h0;
  logic [31:0]          rdata;
  logic [31:0]          st;
  logic                 busy;
  logic [7:0]           dq;
  fess_pkg::fess_pins_t pins;
  int                   mismatches = 0;
  int                   cmp_count  = 0;
  int                   cycles     = 0;
  always #20 clk = ~clk;
  fess_host #(.WIN_CYC(WIN)) u_dut (.MCLK_I(clk), .RST_I(rst), .ADDR_I(adr),
    .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BUSY_O(busy),
    .FL_O(pins), .FL_DQ_I(dq));
  fess_flash_model #(.WIN_CYC(WIN)) u_flash (.clk_i(clk), .erase_fail_i(efail),
    .pins_i(pins), .dq_o(dq));
  // ***********************************
  // Access tasks
  // ***********************************
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wreg(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wreg
  task automatic rreg();
    @(posedge clk);
    adr <= fess_pkg::REG_STAT;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    st = rdata;
  endtask : rreg
  task automatic wait_idle();
    int n = 0;
    @(negedge clk);
    while (busy !== 1'h0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000) begin
      mismatches++;
      $display("ERROR idle wait expected %0d seen %0d", 0, n);
      stop_test();
    end
  endtask : wait_idle
  task automatic run(input fess_pkg::fess_op_t o);
    wreg(fess_pkg::REG_CMD, 32'(o));
    wait_idle();
  endtask : run
  task automatic prog(input logic [18:0] a, input logic [7:0] d);
    wreg(fess_pkg::REG_ADDR, 32'(a));
    wreg(fess_pkg::REG_DATA, 32'(d));
    run(fess_pkg::OP_PROG);
  endtask : prog
  task automatic readb(input logic [18:0] a, input logic [7:0] e);
    wreg(fess_pkg::REG_ADDR, 32'(a));
    run(fess_pkg::OP_READ);
    rreg();
    chk("array byte", 32'(e), 32'(st[7:0]));
  endtask : readb
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("ERROR cycle budget expected %0d seen %0d", LIMIT - 1, cycles);
      stop_test();
    end
  end
  // ***********************************
  // Scenarios
  // ***********************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk("idle pins", 32'h0000_000E, 32'({pins.cs_n, pins.oe_n, pins.we_n, pins.dq_oe}));
    chk("idle busy", 32'h0000_0000, {rdata[30:0], busy});
    rreg();
    chk("stat reset", 32'h0000_0000, st);
    prog(19'h1_0123, 8'h5A);
    prog(19'h5_0010, 8'hA5);
    readb(19'h1_0123, 8'h5A);
    readb(19'h5_0010, 8'hA5);
    prog(19'h1_0123, 8'h00);
    rreg();
    chk("lockout flags", 32'h0000_0001, 32'(st[18:17]));
    readb(19'h1_0123, 8'h5A);
    wreg(fess_pkg::REG_CMD, 32'(fess_pkg::OP_CHIP));
    wreg(fess_pkg::REG_CMD, 32'(fess_pkg::OP_READ));
    wait_idle();
    rreg();
    chk("refused", 32'h0000_0001, 32'(st[21]));
    chk("chip flags", 32'h0000_0000, 32'(st[18:17]));
    readb(19'h1_0123, 8'hFF);
    readb(19'h5_0010, 8'hFF);
    wreg(fess_pkg::REG_STAT, 32'h0000_0000);
    prog(19'h2_0004, 8'h11);
    prog(19'h3_0004, 8'h22);
    prog(19'h6_0004, 8'h33);
    wreg(fess_pkg::REG_ADDR, 32'h0006_0000);
    run(fess_pkg::OP_SECT);
    rreg();
    chk("window open", 32'h0000_0001, 32'(st[20]));
    wreg(fess_pkg::REG_ADDR, 32'h0002_0000);
    run(fess_pkg::OP_ADD);
    rreg();
    chk("sector mask", 32'h0000_0044, 32'(st[15:8]));
    run(fess_pkg::OP_POLL);
    rreg();
    chk("sector flags", 32'h0000_0000, 32'(st[18:17]));
    readb(19'h6_0004, 8'hFF);
    readb(19'h2_0004, 8'hFF);
    readb(19'h3_0004, 8'h22);
    run(fess_pkg::OP_ADD);
    rreg();
    chk("late add", 32'h0000_0001, 32'(st[21]));
    wreg(fess_pkg::REG_STAT, 32'h0000_0000);
    prog(19'h4_0008, 8'h3C);
    prog(19'h0_0040, 8'h77);
    wreg(fess_pkg::REG_ADDR, 32'h0004_0000);
    run(fess_pkg::OP_SECT);
    run(fess_pkg::OP_RESET);
    rreg();
    chk("window shut", 32'h0000_0000, 32'(st[20]));
    readb(19'h4_0008, 8'h3C);
    wreg(fess_pkg::REG_ADDR, 32'h0004_0000);
    run(fess_pkg::OP_SECT);
    run(fess_pkg::OP_SUSP);
    rreg();
    chk("suspend entry", 32'h0000_0000, 32'(st[19]));
    readb(19'h0_0040, 8'h77);
    wreg(fess_pkg::REG_ADDR, 32'h0004_0000);
    run(fess_pkg::OP_RESUME);
    run(fess_pkg::OP_POLL);
    readb(19'h4_0008, 8'hFF);
    efail <= 1'h1;
    run(fess_pkg::OP_CHIP);
    efail <= 1'h0;
    rreg();
    chk("erase fail", 32'h0000_0003, 32'(st[18:17]));
    readb(19'h0_0040, 8'h77);
    stop_test();
  end
endmodule : tb
`default_nettype wire
